// File: common/rlu_defs.svh
// What this block does
// - Accumulator and carry rotate left as nine-bit ring
// - Operand rotate circular: bit 7 to bit 0 and carry
// - Operand rotate sets S Z P; H N cleared
// - Pointer form 0xcb 0x06; register form 00000 plus code
// - Prefix bit picks index register; signed displacement added
// - Accumulator rotate circular: bit 7 to bit 0, carry
// - Accumulator circular keeps S Z P; H N cleared
// - Accumulator circular opcode is 0x07
// - Digit rotate: twelve-bit value rotated one digit left
// - Digits move memory low, memory high, accumulator low
// - Digit rotate reads then writes pointer pair address
// - Digit rotate sets S Z P from accumulator; carry kept
// - No exception or trap from these operations
`ifndef RLU_DEFS_SVH
`define RLU_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RLU_A_GPR_HI 2'h0
`define RLU_A_FLAGS 5'h08
`define RLU_A_IX_LO 5'h09
`define RLU_A_IX_HI 5'h0a
`define RLU_A_IY_LO 5'h0b
`define RLU_A_IY_HI 5'h0c
`define RLU_A_OP0 5'h10
`define RLU_A_OP1 5'h11
`define RLU_A_OP2 5'h12
`define RLU_A_OP3 5'h13
`define RLU_A_CTRL 5'h14

// ----------------------------------------
// Register codes and flag bits
// ----------------------------------------
`define RLU_R_H 3'h4
`define RLU_R_L 3'h5
`define RLU_R_MEM 3'h6
`define RLU_R_A 3'h7
`define RLU_F_S 7
`define RLU_F_Z 6
`define RLU_F_H 4
`define RLU_F_P 2
`define RLU_F_N 1
`define RLU_F_C 0
`define RLU_MSB 7
`define RLU_BYTE_BITS 8

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define RLU_OP_ACC_THRU 8'h17
`define RLU_OP_ACC_CIRC 8'h07
`define RLU_OP_BIT_PFX 8'hcb
`define RLU_OP_EXT_PFX 8'hed
`define RLU_OP_DIGIT 8'h6f
`define RLU_OP_CIRC_GRP 5'h00
`define RLU_OP_IDX_LOW 5'h1d
`define RLU_OP_IDX_HIGH 2'h3
`define RLU_IDX_SEL_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RLU_RST_BYTE 8'h00
`define RLU_RST_WORD 16'h0000

`endif

// File: common/rlu_pkg.sv
`include "rlu_defs.svh"

package rlu_pkg;

  // ----------------------------------------
  // Bus and memory carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rlu_bus_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rlu_mem_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } rlu_mem_rsp_t;

  // ----------------------------------------
  // Block state
  // ----------------------------------------
  typedef enum logic [1:0] {
    RLU_IDLE,
    RLU_RD_WAIT,
    RLU_WR_WAIT
  } rlu_phase_t;

  typedef struct packed {
    rlu_phase_t phase;
    logic [7:0][7:0] gpr;
    logic [7:0] flags;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [3:0][7:0] op;
    logic digit;
    logic busy;
    logic bad;
    logic [7:0] rdata;
    rlu_mem_t mem;
  } rlu_state_t;

endpackage

// File: verilog/rlu_rotate_left_unit.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rlu_defs.svh"

module rlu_rotate_left_unit
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rlu_pkg::rlu_bus_t bus,
  output logic [7:0] bus_rdata_q,
  output rlu_pkg::rlu_mem_t mem_q,
  input wire rlu_pkg::rlu_mem_rsp_t mem_rsp,
  output logic busy_q
);
  import rlu_pkg::*;

  rlu_state_t s_q;
  rlu_state_t s_d;
  logic [7:0] acc;
  logic [7:0] res;
  logic [7:0] opnd;
  logic dec_thru;
  logic dec_circ;
  logic dec_digit;
  logic dec_bit;
  logic dec_idx;
  logic [7:0] reg_src;
  logic [7:0] acc_rot;
  logic [7:0] reg_rot;
  logic [7:0] mem_rot;
  logic [7:0] dig_acc;
  logic [7:0] dig_mem;
  logic [7:0] reg_flags;
  logic [7:0] mem_flags;
  logic [7:0] dig_flags;
  logic [15:0] ptr_addr;
  logic [15:0] idx_base;
  logic [15:0] idx_disp;
  logic [15:0] idx_addr;
  logic [2:0] rcode;
  logic start;

  // ----------------------------------------
  // Flag helper
  // ----------------------------------------
  function automatic logic [7:0] szp_flags
  (
    input logic [7:0] f,
    input logic [7:0] v
  );
    logic [7:0] o;
    o = f;
    o[`RLU_F_S] = v[`RLU_MSB];
    o[`RLU_F_Z] = (v == `RLU_RST_BYTE);
    o[`RLU_F_P] = ~^v;
    o[`RLU_F_H] = 1'b0;
    o[`RLU_F_N] = 1'b0;
    return o;
  endfunction

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  // Carry rotate opcode
  assign dec_thru = (s_q.op[0] == `RLU_OP_ACC_THRU);

  assign dec_circ = (s_q.op[0] == `RLU_OP_ACC_CIRC);

  assign dec_digit = (s_q.op[0] == `RLU_OP_EXT_PFX) && (s_q.op[1] == `RLU_OP_DIGIT);

  assign dec_bit = (s_q.op[0] == `RLU_OP_BIT_PFX)
                   && (s_q.op[1][7:3] == `RLU_OP_CIRC_GRP);

  assign dec_idx = (s_q.op[0][7:6] == `RLU_OP_IDX_HIGH)
                   && (s_q.op[0][4:0] == `RLU_OP_IDX_LOW)
                   && (s_q.op[1] == `RLU_OP_BIT_PFX)
                   && (s_q.op[3][7:3] == `RLU_OP_CIRC_GRP)
                   && (s_q.op[3][2:0] == `RLU_R_MEM);

  // ----------------------------------------
  // Operand addresses
  // ----------------------------------------
  // Pointer pair address
  assign ptr_addr = {s_q.gpr[`RLU_R_H], s_q.gpr[`RLU_R_L]};
  assign idx_base = s_q.op[0][`RLU_IDX_SEL_BIT] ? s_q.iy : s_q.ix;
  assign idx_disp = {{8{s_q.op[2][`RLU_MSB]}}, s_q.op[2]};
  assign idx_addr = idx_base + idx_disp;

  // ----------------------------------------
  // Circular rotate network
  // ----------------------------------------
  assign reg_src = s_q.gpr[s_q.op[1][2:0]];

  // Bit 7 wraps to bit 0
  for (genvar gi = 0; gi < `RLU_BYTE_BITS; gi++)
  begin : g_rot
    if (gi == 0)
    begin : g_wrap
      assign acc_rot[gi] = s_q.gpr[`RLU_R_A][`RLU_MSB];
      assign reg_rot[gi] = reg_src[`RLU_MSB];
      assign mem_rot[gi] = mem_rsp.rdata[`RLU_MSB];
    end
    else
    begin : g_shift
      assign acc_rot[gi] = s_q.gpr[`RLU_R_A][gi - 1];
      assign reg_rot[gi] = reg_src[gi - 1];
      assign mem_rot[gi] = mem_rsp.rdata[gi - 1];
    end
  end

  // ----------------------------------------
  // Digit rotate and flag results
  // ----------------------------------------
  // Three-digit rotate by one digit
  assign dig_acc = {s_q.gpr[`RLU_R_A][7:4], mem_rsp.rdata[7:4]};
  assign dig_mem = {mem_rsp.rdata[3:0], s_q.gpr[`RLU_R_A][3:0]};
  assign reg_flags = szp_flags(s_q.flags, reg_rot);
  assign mem_flags = szp_flags(s_q.flags, mem_rot);
  assign dig_flags = szp_flags(s_q.flags, dig_acc);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    acc = s_q.gpr[`RLU_R_A];
    res = `RLU_RST_BYTE;
    opnd = `RLU_RST_BYTE;
    rcode = s_q.op[1][2:0];
    start = 1'b0;
    s_d.rdata = `RLU_RST_BYTE;

    // Register reads
    if (bus.rd)
    begin
      if (bus.addr[4:3] == `RLU_A_GPR_HI)
      begin
        s_d.rdata = s_q.gpr[bus.addr[2:0]];
      end
      else
      begin
        unique case (bus.addr)
          `RLU_A_FLAGS: s_d.rdata = s_q.flags;
          `RLU_A_IX_LO: s_d.rdata = s_q.ix[7:0];
          `RLU_A_IX_HI: s_d.rdata = s_q.ix[15:8];
          `RLU_A_IY_LO: s_d.rdata = s_q.iy[7:0];
          `RLU_A_IY_HI: s_d.rdata = s_q.iy[15:8];
          `RLU_A_OP0: s_d.rdata = s_q.op[0];
          `RLU_A_OP1: s_d.rdata = s_q.op[1];
          `RLU_A_OP2: s_d.rdata = s_q.op[2];
          `RLU_A_OP3: s_d.rdata = s_q.op[3];
          `RLU_A_CTRL: s_d.rdata = {6'h00, s_q.bad, s_q.busy};
          default: s_d.rdata = `RLU_RST_BYTE;
        endcase
      end
    end

    // Register writes
    if (bus.wr)
    begin
      if (bus.addr[4:3] == `RLU_A_GPR_HI)
      begin
        s_d.gpr[bus.addr[2:0]] = bus.wdata;
      end
      else
      begin
        unique case (bus.addr)
          `RLU_A_FLAGS: s_d.flags = bus.wdata;
          `RLU_A_IX_LO: s_d.ix[7:0] = bus.wdata;
          `RLU_A_IX_HI: s_d.ix[15:8] = bus.wdata;
          `RLU_A_IY_LO: s_d.iy[7:0] = bus.wdata;
          `RLU_A_IY_HI: s_d.iy[15:8] = bus.wdata;
          `RLU_A_OP0: s_d.op[0] = bus.wdata;
          `RLU_A_OP1: s_d.op[1] = bus.wdata;
          `RLU_A_OP2: s_d.op[2] = bus.wdata;
          `RLU_A_OP3: s_d.op[3] = bus.wdata;
          `RLU_A_CTRL: start = 1'b1;
          default: start = 1'b0;
        endcase
      end
    end

    // ----------------------------------------
    // Execution
    // ----------------------------------------
    unique case (s_q.phase)
      RLU_IDLE:
      begin
        if (start)
        begin
          s_d.bad = 1'b0;
          if (dec_thru)
          begin
            res = {acc[6:0], s_q.flags[`RLU_F_C]};
            s_d.gpr[`RLU_R_A] = res;
            s_d.flags[`RLU_F_C] = acc[`RLU_MSB];
            s_d.flags[`RLU_F_H] = 1'b0;
            s_d.flags[`RLU_F_N] = 1'b0;
          end
          else if (dec_circ)
          begin
            res = acc_rot;
            s_d.gpr[`RLU_R_A] = res;
            s_d.flags[`RLU_F_C] = acc[`RLU_MSB];
            s_d.flags[`RLU_F_H] = 1'b0;
            s_d.flags[`RLU_F_N] = 1'b0;
          end
          else if (dec_digit)
          begin
            s_d.digit = 1'b1;
            s_d.mem.req = 1'b1;
            s_d.mem.we = 1'b0;
            s_d.mem.addr = ptr_addr;
            s_d.busy = 1'b1;
            s_d.phase = RLU_RD_WAIT;
          end
          else if (dec_bit)
          begin
            if (rcode == `RLU_R_MEM)
            begin
              s_d.digit = 1'b0;
              s_d.mem.req = 1'b1;
              s_d.mem.we = 1'b0;
              s_d.mem.addr = ptr_addr;
              s_d.busy = 1'b1;
              s_d.phase = RLU_RD_WAIT;
            end
            else
            begin
              opnd = reg_src;
              res = reg_rot;
              s_d.gpr[rcode] = res;
              s_d.flags = reg_flags;
              s_d.flags[`RLU_F_C] = opnd[`RLU_MSB];
            end
          end
          else if (dec_idx)
          begin
            s_d.digit = 1'b0;
            s_d.mem.req = 1'b1;
            s_d.mem.we = 1'b0;
            s_d.mem.addr = idx_addr;
            s_d.busy = 1'b1;
            s_d.phase = RLU_RD_WAIT;
          end
          else
          begin
            s_d.bad = 1'b1;
          end
        end
      end
      RLU_RD_WAIT:
      begin
        if (mem_rsp.ack)
        begin
          opnd = mem_rsp.rdata;
          if (s_q.digit)
          begin
            res = dig_acc;
            s_d.gpr[`RLU_R_A] = res;
            s_d.mem.wdata = dig_mem;
            s_d.flags = dig_flags;
          end
          else
          begin
            res = mem_rot;
            s_d.mem.wdata = res;
            s_d.flags = mem_flags;
            s_d.flags[`RLU_F_C] = opnd[`RLU_MSB];
          end
          s_d.mem.we = 1'b1;
          s_d.phase = RLU_WR_WAIT;
        end
      end
      RLU_WR_WAIT:
      begin
        if (mem_rsp.ack)
        begin
          s_d.mem.req = 1'b0;
          s_d.mem.we = 1'b0;
          s_d.busy = 1'b0;
          s_d.phase = RLU_IDLE;
        end
      end
      default:
      begin
        s_d.phase = RLU_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata_q = s_q.rdata;
  assign mem_q = s_q.mem;
  assign busy_q = s_q.busy;

endmodule // rlu_rotate_left_unit

`default_nettype wire

// File: tb/rlu_rotate_left_props.sv
`timescale 1ns/100ps
`default_nettype none
module rlu_rotate_left_props
(
  input wire logic clk,
  input wire logic rst_n,
  input wire rlu_pkg::rlu_bus_t bus,
  input wire logic [7:0] bus_rdata_q,
  input wire rlu_pkg::rlu_mem_t mem_q,
  input wire rlu_pkg::rlu_mem_rsp_t mem_rsp,
  input wire logic busy_q
);
  import rlu_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Memory operand and bus checks
  // ----------------------------------------
  a_read_first: assert property ($rose(mem_q.req) |-> !mem_q.we)
    else $error("memory op not opened by a read");
  a_read_write: assert property (mem_q.req && !mem_q.we && mem_rsp.ack |=>
    mem_q.req && mem_q.we && mem_q.addr == $past(mem_q.addr))
    else $error("write back missing or moved");
  a_write_end: assert property (mem_q.req && mem_q.we && mem_rsp.ack |=> !mem_q.req && !busy_q)
    else $error("op not closed after write");
  a_req_steady: assert property (mem_q.req && !mem_rsp.ack |=>
    mem_q.req && $stable(mem_q.addr) && $stable(mem_q.we))
    else $error("request changed before answer");
  a_data_steady: assert property (mem_q.req && mem_q.we && !mem_rsp.ack |=> $stable(mem_q.wdata))
    else $error("write data changed before answer");
  a_rot_data: assert property (mem_q.req && !mem_q.we && mem_rsp.ack |=>
    mem_q.wdata == (($past(mem_rsp.rdata) << 1) | ($past(mem_rsp.rdata) >> 7))
    || (mem_q.wdata >> 4) == ($past(mem_rsp.rdata) & 8'h0f))
    else $error("write data not a rotation of read data");
  a_idle_quiet: assert property (!busy_q |-> !mem_q.req)
    else $error("memory request while idle");
  a_rdata_idle: assert property (!$past(bus.rd) |-> bus_rdata_q == 8'h00)
    else $error("read data outside its cycle");
endmodule // rlu_rotate_left_props
bind rlu_rotate_left_unit rlu_rotate_left_props u_props (.clk(clk), .rst_n(rst_n), .bus(bus),
  .bus_rdata_q(bus_rdata_q), .mem_q(mem_q), .mem_rsp(mem_rsp), .busy_q(busy_q));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rlu_pkg::*;
  logic clk;
  logic rst_n;
  rlu_bus_t bus;
  logic [7:0] bus_rdata_q;
  rlu_mem_t mem_q;
  rlu_mem_rsp_t mem_rsp;
  logic busy_q;
  logic pend;
  logic [7:0] mem [logic [15:0]];
  logic [7:0] expq [$];
  logic [7:0] a, f, v, r, d, t;
  logic [15:0] p, e;
  int miscompares;
  int check_count;
  rlu_rotate_left_unit DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .bus_rdata_q(bus_rdata_q),
    .mem_q(mem_q), .mem_rsp(mem_rsp), .busy_q(busy_q));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    check_count++;
    if (x !== s)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] wd);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= ad;
    bus.wdata <= wd;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] ad, input logic [7:0] x);
    expq.push_back(x);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= ad;
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  task automatic ex(input logic [31:0] ops);
    for (int i = 0; i < 4; i++)
      wr(5'h10 + 5'(i), ops[8*i +: 8]);
    wr(5'h14, 8'h00);
    repeat (2) @(posedge clk);
    while (busy_q !== 1'b0)
      @(posedge clk);
  endtask
  task automatic test_done;
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, monitor, memory, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (pend)
      chk("bus_rdata_q", expq.pop_front(), bus_rdata_q);
    pend <= bus.rd;
  end
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (mem_q.req === 1'b1)
      begin
        repeat ($urandom_range(2)) @(posedge clk);
        if (mem_q.we)
          mem[mem_q.addr] = mem_q.wdata;
        mem_rsp.ack <= 1'b1;
        mem_rsp.rdata <= mem_q.we ? 8'h5a : mem[mem_q.addr];
        @(posedge clk);
        mem_rsp.ack <= 1'b0;
        mem_rsp.rdata <= ~mem_rsp.rdata;
      end
    end
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    test_done;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    bus = '0;
    mem_rsp = '0;
    pend = 1'b0;
    void'($urandom(9471));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h08, 8'h00);
    for (int i = 7; i < 32; i += 8)
      rd(5'(i), 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      a = 8'($urandom);
      f = 8'($urandom);
      v = 8'($urandom);
      d = 8'($urandom);
      p = 16'($urandom);
      r = {v[6:0], v[7]};
      wr(5'h07, a);
      wr(5'h08, f);
      ex(32'h17);
      rd(5'h07, {a[6:0], f[0]});
      rd(5'h08, {f[7:5], 1'b0, f[3:2], 1'b0, a[7]});
      wr(5'h07, v);
      ex(32'h07);
      rd(5'h07, r);
      rd(5'h08, {f[7:5], 1'b0, f[3:2], 1'b0, v[7]});
      if (k != 6)
      begin
        wr(5'(k), v);
        ex({16'h0, 8'(k), 8'hcb});
        rd(5'(k), r);
        rd(5'h08, {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, v[7]});
      end
      wr(5'h04, p[15:8]);
      wr(5'h05, p[7:0]);
      wr(5'h09, p[7:0]);
      wr(5'h0a, p[15:8]);
      wr(5'h0b, ~p[7:0]);
      wr(5'h0c, ~p[15:8]);
      e = (k % 3 == 2) ? ~p : p;
      if (k % 3 != 0)
        e = e + {{8{d[7]}}, d};
      mem[e] = v;
      ex(k % 3 == 0 ? 32'h06cb : {8'h06, d, 8'hcb, (k % 3 == 1) ? 8'hdd : 8'hfd});
      chk("mem", r, mem[e]);
      rd(5'h08, {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, v[7]});
      wr(5'h07, a);
      mem[p] = d;
      ex(32'h6fed);
      t = {a[7:4], d[7:4]};
      chk("mem", {d[3:0], a[3:0]}, mem[p]);
      rd(5'h07, t);
      rd(5'h08, {t[7], t == 8'h00, f[5], 1'b0, f[3], ~^t, 1'b0, v[7]});
    end
    ex(32'h00);
    rd(5'h14, 8'h02);
    rd(5'h07, t);
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule // testbench
`default_nettype wire
